// ===== rtl/rtc_pkg.sv
// constants shared by the real-time clock files
`default_nettype none
package rtc_pkg;
  localparam logic [3:0] ADDR_CTRL      = 4'h0;
  localparam logic [3:0] ADDR_STATUS    = 4'h1;
  localparam logic [3:0] ADDR_PRESCALE  = 4'h2;
  localparam logic [3:0] ADDR_CNT_LO    = 4'h3;
  localparam logic [3:0] ADDR_CNT_HI    = 4'h4;
  localparam logic [3:0] ADDR_CMP_LO    = 4'h5;
  localparam logic [3:0] ADDR_CMP_HI    = 4'h6;
  localparam logic [3:0] ADDR_DIVCNT    = 4'h7;
  localparam logic [3:0] ADDR_BKP_BASE  = 4'h8;
  localparam int         NUM_BKP        = 10;
  localparam int         BKP_W          = 16;
  localparam int         PRE_W          = 20;
  localparam int         CNT_W          = 32;
  // ctrl fields
  localparam int         CTRL_SRC_LSB   = 0;
  localparam int         CTRL_ALR_IE    = 2;
  localparam int         CTRL_SEC_IE    = 3;
  localparam int         CTRL_CAL_OE    = 4;
  localparam int         CTRL_RUN       = 5;
  // bank bit moves the backup window up by one bank of eight words
  localparam int         CTRL_BKP_BANK  = 6;
  localparam int         BKP_BANK_SZ    = 8;
  localparam logic [15:0] CTRL_RST      = 16'h0020;
  // status fields, write one to clear
  localparam int         STAT_SEC       = 0;
  localparam int         STAT_ALR       = 1;
  // slow input is 32768 Hz, reload gives one tick per second
  localparam int         LSE_HZ         = 32768;
  localparam int         TICK_S         = 1;
  localparam logic [19:0] PRE_RST       = 20'(LSE_HZ * TICK_S - 1);
  localparam int         HSE_DIV        = 128;
  localparam int         CAL_HZ         = 512;
  localparam logic [5:0] CAL_HALF       = 6'(LSE_HZ / CAL_HZ / 2 - 1);
  typedef enum logic [1:0] {SRC_LSE, SRC_LSI, SRC_HSE} src_e;
endpackage
`default_nettype wire

// ===== rtl/rtc_sync.sv
// two-flop synchroniser with rising-edge pulse for one clock source, slow or fast external
`default_nettype none
module rtc_sync (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_ce,
  input  wire logic i_async,
  output logic      o_rise
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else if (i_ce) begin
      s1_r <= i_async;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  assign o_rise = i_ce & s2_r & ~s3_r;
endmodule
`default_nettype wire

// ===== rtl/rtc_counter_alarm_backup.sv
// real-time clock: source select, prescaler, counter, alarm, backup store
// What this block does
// RULE1 - programmable 32-bit counter advancing once per time-base tick
// RULE2 - alarm when counter equals software compare register
// RULE3 - alarm interrupt and periodic tick interrupt
// RULE4 - 20-bit prescaler, reset reload gives one tick per second at 32.768 kHz
// RULE5 - source: 32.768 kHz crystal, 40 kHz RC, or fast external clock /128
// RULE6 - optional 512 Hz reference output for crystal calibration
// RULE7 - ten 16-bit backup registers holding user data
// RULE8 - counter and source keep running in Stop and Standby
// RULE9 - alarm drives an external event line to wake from Stop
// RULE10 - alarm during Standby makes the device exit Standby
// RULE11 - backup-domain registers survive Standby, unlike other registers
// RULE12 - flags stay set until cleared; interrupt is flag and enable
`default_nettype none
module rtc_counter_alarm_backup (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_bkp_rst,
  input  wire logic        i_ce,
  input  wire logic        i_standby,
  input  wire logic        i_lse,
  input  wire logic        i_lsi,
  input  wire logic        i_hse,
  input  wire logic [3:0]  i_addr,
  input  wire logic [15:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [15:0] o_rdata,
  output logic             o_irq_alarm,
  output logic             o_irq_sec,
  output logic             o_alarm_event,
  output logic             o_standby_exit,
  output logic             o_cal_out
);
  logic [15:0]       ctrl_r;
  logic [1:0]        stat_r;
  logic [19:0]       reload_r;
  logic [19:0]       div_r;
  logic [31:0]       cnt_r;
  logic [31:0]       cmp_r;
  logic [15:0]       bkp_r [rtc_pkg::NUM_BKP];
  logic [6:0]        hse_div_r;
  logic              hse_clk_r;
  logic [5:0]        cal_div_r;
  logic              cal_r;
  logic              event_r;
  logic              exit_r;
  logic [15:0]       rdata_r;
  logic              lse_rise;
  logic              lsi_rise;
  logic              hse_rise;
  logic              src_edge;
  logic              tick;
  logic              match;
  logic              match_d_r;
  logic              alarm_hit;
  logic [1:0]        src;
  logic [3:0]        bkp_idx;
  logic              bkp_sel;
  logic [3:0]        bkp_off;
  logic              bkp_bank;
  logic              run_en;
  logic              alr_ie;
  logic              sec_ie;
  logic              cal_oe;
  logic              wr_ctrl;
  logic              wr_stat;
  logic              wr_pre;
  logic              wr_div;
  logic              wr_cnt_lo;
  logic              wr_cnt_hi;
  logic              wr_cmp_lo;
  logic              wr_cmp_hi;
  logic              wr_bkp;
  logic              clr_sec;
  logic              clr_alr;
  logic              sec_flag_r;
  logic              alr_flag_r;
  logic              hse_wrap;
  logic              cal_wrap;
  logic [19:0]       div_nxt;
  logic [31:0]       cnt_nxt;
  logic [31:0]       cmp_nxt;
  logic [15:0]       rdata_nxt;

  rtc_sync u_lse (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_async(i_lse),
                  .o_rise(lse_rise));
  rtc_sync u_lsi (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_async(i_lsi),
                  .o_rise(lsi_rise));
  rtc_sync u_hse (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_async(i_hse),
                  .o_rise(hse_rise));

  assign src = ctrl_r[rtc_pkg::CTRL_SRC_LSB +: 2];
  assign run_en   = ctrl_r[rtc_pkg::CTRL_RUN];
  assign bkp_bank = ctrl_r[rtc_pkg::CTRL_BKP_BANK];
  assign alr_ie   = ctrl_r[rtc_pkg::CTRL_ALR_IE];
  assign sec_ie   = ctrl_r[rtc_pkg::CTRL_SEC_IE];
  assign cal_oe   = ctrl_r[rtc_pkg::CTRL_CAL_OE];

  // write strobes per register, qualified by the clock enable
  assign wr_ctrl   = i_ce && i_wr && (i_addr == rtc_pkg::ADDR_CTRL);
  assign wr_stat   = i_ce && i_wr && (i_addr == rtc_pkg::ADDR_STATUS);
  assign wr_pre    = i_ce && i_wr && (i_addr == rtc_pkg::ADDR_PRESCALE);
  assign wr_div    = i_ce && i_wr && (i_addr == rtc_pkg::ADDR_DIVCNT);
  assign wr_cnt_lo = i_ce && i_wr && (i_addr == rtc_pkg::ADDR_CNT_LO);
  assign wr_cnt_hi = i_ce && i_wr && (i_addr == rtc_pkg::ADDR_CNT_HI);
  assign wr_cmp_lo = i_ce && i_wr && (i_addr == rtc_pkg::ADDR_CMP_LO);
  assign wr_cmp_hi = i_ce && i_wr && (i_addr == rtc_pkg::ADDR_CMP_HI);
  assign wr_bkp    = i_ce && i_wr && bkp_sel;
  assign clr_sec   = wr_stat && i_wdata[rtc_pkg::STAT_SEC];
  assign clr_alr   = wr_stat && i_wdata[rtc_pkg::STAT_ALR];

  // fast external clock divided by 128 before use
  assign hse_wrap = (hse_div_r == 7'(rtc_pkg::HSE_DIV - 1));

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      hse_div_r <= 7'h00;
    end else if (i_ce && hse_rise) begin
      hse_div_r <= hse_div_r + 7'h01;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      hse_clk_r <= 1'b0;
    end else if (i_ce) begin
      hse_clk_r <= hse_rise && hse_wrap;  // see RULE5
    end
  end

  always_comb begin
    case (src)  // see RULE5
      2'(rtc_pkg::SRC_LSE): src_edge = lse_rise;
      2'(rtc_pkg::SRC_LSI): src_edge = lsi_rise;
      2'(rtc_pkg::SRC_HSE): src_edge = hse_clk_r;
      default:              src_edge = 1'b0;
    endcase
  end

  // prescaler ignores low-power mode inputs: it keeps counting in Stop and Standby
  assign tick = src_edge && ctrl_r[rtc_pkg::CTRL_RUN] && (div_r == 20'h00000);  // see RULE8

  // a prescale write keeps the upper four reload bits and restarts the divider
  always_comb begin
    div_nxt = div_r;
    if (wr_pre) begin
      div_nxt = {reload_r[19:16], i_wdata};
    end else if (src_edge && run_en) begin
      div_nxt = (div_r == 20'h00000) ? reload_r : div_r - 20'h00001;  // see RULE4
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      div_r <= rtc_pkg::PRE_RST;
    end else if (i_ce) begin
      div_r <= div_nxt;
    end
  end

  // reload: low 16 bits from the prescale word, top 4 from bits 3:0 of the divider word
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      reload_r <= rtc_pkg::PRE_RST;  // see RULE4
    end else if (wr_pre) begin
      reload_r[15:0] <= i_wdata;
    end else if (wr_div) begin
      reload_r[19:16] <= i_wdata[3:0];
    end
  end

  always_comb begin
    cnt_nxt = cnt_r;
    if (wr_cnt_lo) begin
      cnt_nxt[15:0] = i_wdata;
    end else if (wr_cnt_hi) begin
      cnt_nxt[31:16] = i_wdata;
    end else if (tick) begin
      cnt_nxt = cnt_r + 32'h0000_0001;  // see RULE1
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_r <= 32'h0000_0000;
    end else if (i_ce) begin
      cnt_r <= cnt_nxt;
    end
  end

  always_comb begin
    cmp_nxt = cmp_r;
    if (wr_cmp_lo) begin
      cmp_nxt[15:0] = i_wdata;
    end else if (wr_cmp_hi) begin
      cmp_nxt[31:16] = i_wdata;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cmp_r <= 32'hFFFF_FFFF;
    end else if (i_ce) begin
      cmp_r <= cmp_nxt;
    end
  end

  // alarm fires once when the count first equals compare
  assign match = (cnt_r == cmp_r);  // see RULE2
  assign alarm_hit = match && !match_d_r;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      match_d_r <= 1'b1;
    end else if (i_ce) begin
      match_d_r <= match;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl_r <= rtc_pkg::CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_r <= {9'h000, i_wdata[6:0]};
    end
  end

  // sticky flags, write one to clear; a new event wins over the clear
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sec_flag_r <= 1'b0;
    end else if (i_ce) begin
      sec_flag_r <= tick | (sec_flag_r & ~clr_sec);  // see RULE12
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      alr_flag_r <= 1'b0;
    end else if (i_ce) begin
      alr_flag_r <= alarm_hit | (alr_flag_r & ~clr_alr);  // see RULE12
    end
  end

  assign stat_r[rtc_pkg::STAT_SEC] = sec_flag_r;
  assign stat_r[rtc_pkg::STAT_ALR] = alr_flag_r;

  assign o_irq_sec   = sec_flag_r & sec_ie;  // see RULE3
  assign o_irq_alarm = alr_flag_r & alr_ie;  // see RULE3

  // event line pulse to the wake logic; standby exit held until standby drops
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      event_r <= 1'b0;
    end else if (i_ce) begin
      event_r <= alarm_hit;  // see RULE9
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      exit_r <= 1'b0;
    end else if (i_ce) begin
      if (!i_standby) begin
        exit_r <= 1'b0;
      end else if (alarm_hit) begin
        exit_r <= 1'b1;  // see RULE10
      end
    end
  end

  assign o_alarm_event  = event_r;
  assign o_standby_exit = exit_r;

  // 512 Hz calibration output, toggled every 32 slow edges
  assign cal_wrap = (cal_div_r == rtc_pkg::CAL_HALF);

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cal_div_r <= 6'h00;
    end else if (i_ce && src_edge) begin
      cal_div_r <= cal_wrap ? 6'h00 : cal_div_r + 6'h01;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cal_r <= 1'b0;
    end else if (i_ce && src_edge && cal_wrap) begin
      cal_r <= ~cal_r & cal_oe;  // see RULE6
    end
  end

  assign o_cal_out = cal_r;

  // eight-word window; the bank bit reaches backup words 8 and 9
  assign bkp_off = i_addr - rtc_pkg::ADDR_BKP_BASE;
  assign bkp_idx = bkp_bank ? bkp_off + 4'(rtc_pkg::BKP_BANK_SZ) : bkp_off;
  assign bkp_sel = (i_addr >= rtc_pkg::ADDR_BKP_BASE) &&
                   (bkp_idx < 4'(rtc_pkg::NUM_BKP));

  // backup store clears only on its own domain reset, so standby keeps it
  always_ff @(posedge i_clk or posedge i_bkp_rst) begin
    if (i_bkp_rst) begin
      for (int k = 0; k < rtc_pkg::NUM_BKP; k++) begin
        bkp_r[k] <= 16'h0000;  // see RULE11
      end
    end else if (wr_bkp) begin
      bkp_r[bkp_idx] <= i_wdata;  // see RULE7
    end
  end

  // read data one cycle after the strobe, zero otherwise
  always_comb begin
    rdata_nxt = 16'h0000;
    if (i_rd) begin
      case (i_addr)
        rtc_pkg::ADDR_CTRL:     rdata_nxt = ctrl_r;
        rtc_pkg::ADDR_STATUS:   rdata_nxt = {14'h0000, stat_r};
        rtc_pkg::ADDR_PRESCALE: rdata_nxt = reload_r[15:0];
        rtc_pkg::ADDR_CNT_LO:   rdata_nxt = cnt_r[15:0];
        rtc_pkg::ADDR_CNT_HI:   rdata_nxt = cnt_r[31:16];
        rtc_pkg::ADDR_CMP_LO:   rdata_nxt = cmp_r[15:0];
        rtc_pkg::ADDR_CMP_HI:   rdata_nxt = cmp_r[31:16];
        rtc_pkg::ADDR_DIVCNT:   rdata_nxt = {12'h000, div_r[19:16]};
        default:                rdata_nxt = bkp_sel ? bkp_r[bkp_idx] : 16'h0000;
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rdata_r <= 16'h0000;
    end else if (i_ce) begin
      rdata_r <= rdata_nxt;
    end
  end

  assign o_rdata = rdata_r;
endmodule
`default_nettype wire

// ===== bench/rtc_counter_alarm_backup_chk.sv
// port-level assertions for the real-time clock
`default_nettype none
module rtc_chk (
  input wire logic        i_clk,
  input wire logic        i_rst,
  input wire logic        i_ce,
  input wire logic        i_standby,
  input wire logic [3:0]  i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [15:0] o_rdata,
  input wire logic        o_irq_alarm,
  input wire logic        o_irq_sec,
  input wire logic        o_alarm_event,
  input wire logic        o_standby_exit
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  a_event_pulse: assert property (o_alarm_event && i_ce |=> !o_alarm_event)
    else $error("alarm event too long");
  a_exit_clear: assert property (!i_standby && i_ce |=> !o_standby_exit)
    else $error("exit stays without standby");
  a_exit_held: assert property (o_standby_exit && i_standby && i_ce |=> o_standby_exit)
    else $error("exit dropped in standby");
  a_event_exit: assert property (o_alarm_event && i_standby && $past(i_standby) &&
    $past(i_standby, 2) |-> ##[0:2] o_standby_exit) else $error("alarm gave no exit");
  a_rdata_idle: assert property ($past(i_ce) && !$past(i_rd) |-> o_rdata == 16'h0000)
    else $error("read data outside read slot");
  a_bkp_echo: assert property (i_ce && i_wr && i_addr >= rtc_pkg::ADDR_BKP_BASE
    ##1 i_ce && i_rd && i_addr == $past(i_addr) |=> o_rdata == $past(i_wdata, 2))
    else $error("backup word not kept");
  a_alarm_hold: assert property (o_irq_alarm && !(i_ce && i_wr) |=> o_irq_alarm)
    else $error("alarm irq dropped alone");
  a_tick_hold: assert property (o_irq_sec && !(i_ce && i_wr) |=> o_irq_sec)
    else $error("tick irq dropped alone");
  cover property (o_alarm_event && i_standby);
  cover property (o_irq_sec);
  cover property (i_wr ##1 i_rd);
endmodule
bind rtc_counter_alarm_backup rtc_chk i_rtc_chk (.*);
`default_nettype wire

// ===== bench/tb_top.sv
// self-checking bench for the real-time clock
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk = 1'b0, rst = 1'b1, brst = 1'b1, sb = 1'b0, lse = 1'b0;
  logic        lsi = 1'b0, high_speed_external_clock = 1'b0, we = 1'b0, re = 1'b0, irq_a, irq_s, evt, sbx, cal;
  logic [2:0]  run = 3'h1;
  logic [3:0]  addr = 4'h0;
  logic [15:0] wdata = 16'h0000, q, rdata;
  int          n_errors = 0, check_count = 0, n_evt = 0, cyc = 0;
  always #5 clk = ~clk;
  always #80 if (run[0]) lse = ~lse;
  always #100 if (run[1]) lsi = ~lsi;
  always #20 if (run[2]) high_speed_external_clock = ~high_speed_external_clock;
  rtc_counter_alarm_backup i_rtc_counter_alarm_backup (
    .i_clk(clk), .i_rst(rst), .i_bkp_rst(brst), .i_ce(1'b1), .i_standby(sb), .i_lse(lse),
    .i_lsi(lsi), .i_hse(high_speed_external_clock), .i_addr(addr), .i_wdata(wdata), .i_wr(we), .i_rd(re),
    .o_rdata(rdata), .o_irq_alarm(irq_a), .o_irq_sec(irq_s), .o_alarm_event(evt),
    .o_standby_exit(sbx), .o_cal_out(cal));
  task automatic conclude();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(negedge clk) begin
    cyc++;
    if (evt === 1'b1) n_evt++;
    if (cyc == 20000) begin
      n_errors++;
      conclude();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL %0t %s", $time, m);
    end
  endtask
  // one bus cycle; q holds the read data for this cycle's strobe, sampled just after the clock edge
  task automatic bus(input logic w, r, input logic [3:0] a, input logic [15:0] d);
    we <= w;
    re <= r;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    #1 q = rdata;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d); bus(1'b1, 1'b0, a, d); endtask
  task automatic rd(input logic [3:0] a); bus(1'b0, 1'b1, a, 16'h0000); endtask
  task automatic idle(input int n); repeat (n) bus(1'b0, 1'b0, 4'h0, 16'h0000); endtask
  task automatic wait_stat(input int b);
    int k = 0;
    do begin
      rd(rtc_pkg::ADDR_STATUS);
      k++;
    end while (q[b] !== 1'b1 && k < 3000);
    chk(q[b], 1'b1, "status flag");
  endtask
  task automatic t_reset();
    rd(rtc_pkg::ADDR_CTRL);
    chk(q, rtc_pkg::CTRL_RST, "ctrl reset");
    rd(rtc_pkg::ADDR_PRESCALE);
    chk(q, rtc_pkg::PRE_RST[15:0], "reload reset");
    rd(rtc_pkg::ADDR_CMP_HI);
    chk(q, 16'hFFFF, "compare reset");
  endtask
  task automatic t_backup();
    for (int i = 0; i < 8; i++) begin
      wr(rtc_pkg::ADDR_BKP_BASE + 4'(i), 16'hA5C0 + 16'(i));
      rd(rtc_pkg::ADDR_BKP_BASE + 4'(i));
      chk(q, 16'hA5C0 + 16'(i), "backup echo");
    end
    wr(rtc_pkg::ADDR_CTRL, 16'h0060);
    for (int i = 0; i < 2; i++) begin
      wr(rtc_pkg::ADDR_BKP_BASE + 4'(i), 16'h5A08 + 16'(i));
      rd(rtc_pkg::ADDR_BKP_BASE + 4'(i));
      chk(q, 16'h5A08 + 16'(i), "backup bank echo");
    end
    wr(rtc_pkg::ADDR_CTRL, 16'h0020);
    rd(rtc_pkg::ADDR_BKP_BASE);
    chk(q, 16'hA5C0, "backup bank alias");
    rst <= 1'b1;
    idle(2);
    rst <= 1'b0;
    rd(rtc_pkg::ADDR_BKP_BASE + 4'h7);
    chk(q, 16'hA5C7, "backup lost");
    brst <= 1'b1;
    idle(2);
    brst <= 1'b0;
    rd(rtc_pkg::ADDR_BKP_BASE);
    chk(q, 16'h0000, "backup clear");
  endtask
  task automatic t_tick();
    sb <= 1'b1;
    wr(rtc_pkg::ADDR_DIVCNT, 16'h0000);
    wr(rtc_pkg::ADDR_PRESCALE, 16'h0003);
    wr(rtc_pkg::ADDR_CTRL, 16'h0028);
    wait_stat(0);
    wr(rtc_pkg::ADDR_STATUS, 16'h0001);
    wr(rtc_pkg::ADDR_CNT_LO, 16'hFFFF);
    wr(rtc_pkg::ADDR_CNT_HI, 16'h0000);
    chk(irq_s, 1'b0, "tick irq clear");
    wait_stat(0);
    chk(irq_s, 1'b1, "tick irq");
    rd(rtc_pkg::ADDR_CNT_LO);
    chk(q, 16'h0000, "count low");
    rd(rtc_pkg::ADDR_CNT_HI);
    chk(q, 16'h0001, "count carry");
    idle(80);
    chk(irq_s, 1'b1, "tick flag dropped");
    wr(rtc_pkg::ADDR_CTRL, 16'h0020);
    chk(irq_s, 1'b0, "tick irq mask");
  endtask
  task automatic t_alarm();
    logic [15:0] lo;
    wr(rtc_pkg::ADDR_CTRL, 16'h0024);
    wr(rtc_pkg::ADDR_STATUS, 16'h0003);
    wait_stat(0);
    rd(rtc_pkg::ADDR_CNT_LO);
    lo = q;
    rd(rtc_pkg::ADDR_CNT_HI);
    wr(rtc_pkg::ADDR_CMP_HI, q);
    wr(rtc_pkg::ADDR_CMP_LO, lo + 16'h0001);
    n_evt = 0;
    wait_stat(1);
    chk(irq_a, 1'b1, "alarm irq");
    rd(rtc_pkg::ADDR_CNT_LO);
    chk(q, lo + 16'h0001, "alarm count");
    chk(16'(n_evt), 16'h0001, "event pulses");
    chk(sbx, 1'b1, "standby exit");
    sb <= 1'b0;
    idle(2);
    chk(sbx, 1'b0, "exit held");
    wr(rtc_pkg::ADDR_STATUS, 16'h0002);
    chk(irq_a, 1'b0, "alarm irq clear");
  endtask
  task automatic t_src();
    for (int s = 0; s < 3; s++) begin
      run <= 3'(1 << s);
      wr(rtc_pkg::ADDR_CTRL, 16'h0020 | 16'(s));
      wr(rtc_pkg::ADDR_STATUS, 16'h0001);
      wait_stat(0);
    end
  endtask
  task automatic t_cal();
    int k;
    logic c;
    run <= 3'h1;
    wr(rtc_pkg::ADDR_CTRL, 16'h0030);
    for (int n = 0; n < 2; n++) begin
      c = cal;
      k = 0;
      while (cal === c && k < 2000) begin
        @(negedge clk);
        k++;
      end
    end
    @(posedge clk);
    chk(16'(k), 16'h0200, "cal half period");
    wr(rtc_pkg::ADDR_CTRL, 16'h0020);
    idle(600);
    chk(cal, 1'b0, "cal off");
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    brst <= 1'b0;
    t_reset();
    t_backup();
    t_tick();
    t_alarm();
    t_src();
    t_cal();
    conclude();
  end
endmodule
`default_nettype wire
